// ===== rcfs_supervisor.v
// Fault supervisor for one CPU of a lock-stepped redundant pair
//
// Chosen here: the address map and the strobed register port.
`include "rcfs_defs.vh"
`default_nettype none
module rcfs_supervisor (
    // Clock, reset, enable
    input wire CLOCK,
    input wire RST_N,
    input wire CE,
    // Register port
    input wire [3:0] ADDR,
    input wire [7:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [7:0] RDATA,
    // Bus streams of own and partner CPU
    input wire [15:0] OWN_ADDR,
    input wire [15:0] PARTNER_ADDR,
    input wire [7:0] OWN_DATA,
    input wire [7:0] PARTNER_DATA,
    input wire [3:0] OWN_CTRL,
    input wire [3:0] PARTNER_CTRL,
    // Partner status
    input wire PARTNER_IS_MASTER,
    input wire PARTNER_FATAL,
    // Processor handshake
    input wire INSTR_DONE,
    // Power supply signals
    input wire POWER_FAIL_WARNING,
    input wire MEMORY_PROTECT,
    input wire CENTRAL_RESET,
    // Outputs
    output reg COMPARE_MISMATCH_INTERRUPT,
    output reg SYNC_MODE,
    output reg INTERCPU_LINK_EN,
    output reg REDUNDANT_OK,
    output reg PROCESS_HALT,
    output reg FETCH_EN,
    output reg MEM_ACCESS_EN,
    output reg CLEAR_USER_MEM,
    output reg LOAD_ABORT,
    output reg SELFTEST_START,
    output reg INIT_RUN,
    output reg [2:0] MODE
);

// ----------------------------------------------------------------------
// State and registers
// ----------------------------------------------------------------------
localparam ST_BASIC = 3'h0;
localparam ST_INIT = 3'h1;
localparam ST_RUN = 3'h2;
localparam ST_PRIMARY = 3'h3;
localparam ST_SELFTEST = 3'h4;
localparam ST_RESOLVE = 3'h5;
localparam ST_DEAD = 3'h6;

reg [2:0] state;
reg [7:0] ctrl;
reg [7:0] diag;
reg [15:0] cap_addr;
reg [3:0] cap_ctrl;
reg [20:0] dead_cnt;
reg [7:0] dead_ms;
reg fault_seen;
reg pf_stop;
reg [2:0] next_mode;
reg next_clear;

// Register map seen by the local software
//   0 control: sync request (self-clearing), loading, pairing kind, init done
//   1 status: sync, redundancy ok, fault seen, fetch stopped, mode
//   2 captured address, low byte
//   3 captured control lines beside the captured address top nibble
//   4 diagnosis results, written by the fault-locating routine
//   5 dead time in milliseconds, clamped to the allowed window
// Unmapped offsets read as zero and ignore writes, so probing is harmless.
// Mode is deliberately not writable: only resolution, a mismatch in backup mode and reset move it,
// which keeps a stray store from promoting a CPU to master.
// The captured lines stay put until the next mismatch overwrites them,
// so software may read them at leisure during the dead time.

// Comparison only runs while the pair is coupled; once split the two
// streams differ legitimately and must not raise the interrupt.
wire mismatch = SYNC_MODE && ((OWN_ADDR != PARTNER_ADDR) || (OWN_DATA != PARTNER_DATA)
    || (OWN_CTRL != PARTNER_CTRL));
wire is_master = (MODE == `RCFS_MODE_MASTER);
// Warning stands and the processor is between instructions: fetch no more
wire pf_block = POWER_FAIL_WARNING && (INSTR_DONE || !FETCH_EN);

// Dead time in cycles, clamped to the allowed window
// Software sets the figure per fault class; a zero or oversized value
// is pulled into range rather than refused, so a bad setting still
// leaves the user program suspended long enough for diagnosis.
function [20:0] dead_cycles;
    input [7:0] ms;
    reg [31:0] cyc;
    reg [31:0] lim_lo;
    reg [31:0] lim_hi;
    begin
        cyc = ms * (`RCFS_CLK_MHZ * 1000);
        lim_lo = `RCFS_DEAD_MIN_CYC;
        lim_hi = `RCFS_DEAD_MAX_CYC;
        if (cyc < lim_lo)
            cyc = lim_lo;
        else if (cyc > lim_hi)
            cyc = lim_hi;
        dead_cycles = cyc[20:0];
    end
endfunction

// ----------------------------------------------------------------------
// Mode resolution from diagnosis results
// ----------------------------------------------------------------------
// Priority, highest first:
//   fatal fault here         -> stop
//   partner reports fatal    -> take mastership
//   both sides faulty        -> master keeps, other fails
//   fault in this CPU only   -> depends on pairing kind and role
//   fault in the partner     -> standby may take over
//   nothing found            -> master keeps, other goes passive
// Fatal results are checked first because a stopped CPU must never
// end up holding mastership whatever the other flags say.
// The result is only applied in the resolve state, so flags that
// software is still writing cannot move the mode early.
always @* begin
    next_mode = MODE;
    next_clear = 1'b0;
    if (diag[`RCFS_DIAG_FATAL]) begin
        next_mode = `RCFS_MODE_STOP;
    end else if (PARTNER_FATAL) begin
        next_mode = `RCFS_MODE_MASTER;
    end else if (diag[`RCFS_DIAG_SELF_FAULT] && diag[`RCFS_DIAG_PARTNER_FAULT]) begin
        next_mode = is_master ? `RCFS_MODE_MASTER : `RCFS_MODE_FAILURE;
    end else if (diag[`RCFS_DIAG_SELF_FAULT]) begin
        if (is_master && ctrl[`RCFS_CTRL_PAIRING] == `RCFS_PAIR_RESERVE)
            next_mode = `RCFS_MODE_FAILURE;
        else if (is_master)
            next_mode = `RCFS_MODE_MASTER;
        else
            next_mode = `RCFS_MODE_FAILURE;
    end else if (diag[`RCFS_DIAG_PARTNER_FAULT]) begin
        if (!is_master && ctrl[`RCFS_CTRL_PAIRING] == `RCFS_PAIR_RESERVE && PARTNER_IS_MASTER)
            next_mode = `RCFS_MODE_MASTER;
        else if (!is_master)
            next_mode = `RCFS_MODE_PASSIVE;
    end else begin
        next_mode = is_master ? `RCFS_MODE_MASTER : `RCFS_MODE_PASSIVE;
    end
    // Backup side of a backup pairing holds stale data
    if (ctrl[`RCFS_CTRL_PAIRING] == `RCFS_PAIR_BACKUP && !is_master)
        next_clear = 1'b1;
end

// ----------------------------------------------------------------------
// Main sequencer
// ----------------------------------------------------------------------
// Flow: basic -> init -> run; a mismatch in run goes to primary
// diagnosis, optionally self-test, then resolution and the dead time.
// Loading faults and faults in backup mode skip diagnosis entirely.
// Central reset overrides every state, but the register port and the
// power sequencing stay live so software can still inspect a halt.
// All state freezes while the clock enable is low; pulses then stretch
// until the enable returns, which downstream logic must tolerate.
// Every output is registered, so each one lags its cause by one edge;
// the partner sees the same lag, which keeps the pair in step.
// A mismatch outside the run state is ignored: the pair is already
// split there, and comparison only restarts with a new sync run.
always @(posedge CLOCK) begin
    if (!RST_N) begin
        // Basic state with the program halted and memory shut off;
        // the sync request and loading flags start cleared.
        state <= ST_BASIC;
        MODE <= `RCFS_MODE_PASSIVE;
        ctrl <= `RCFS_CTRL_RESET;
        diag <= 8'h00;
        cap_addr <= 16'h0000;
        cap_ctrl <= 4'h0;
        dead_cnt <= 21'h000000;
        dead_ms <= 8'h05;
        fault_seen <= 1'b0;
        pf_stop <= 1'b0;
        COMPARE_MISMATCH_INTERRUPT <= 1'b0;
        SYNC_MODE <= 1'b0;
        INTERCPU_LINK_EN <= 1'b0;
        REDUNDANT_OK <= 1'b0;
        PROCESS_HALT <= 1'b1;
        FETCH_EN <= 1'b0;
        MEM_ACCESS_EN <= 1'b0;
        CLEAR_USER_MEM <= 1'b0;
        LOAD_ABORT <= 1'b0;
        SELFTEST_START <= 1'b0;
        INIT_RUN <= 1'b0;
        RDATA <= 8'h00;
    end else if (CE) begin
        // Pulses default low
        COMPARE_MISMATCH_INTERRUPT <= 1'b0;
        SELFTEST_START <= 1'b0;
        CLEAR_USER_MEM <= 1'b0;
        LOAD_ABORT <= 1'b0;
        // Register writes
        // Diagnosis results and the dead time may be rewritten at any time;
        // the sequencer samples them only in the states that use them.
        if (WR) begin
            case (ADDR)
                `RCFS_REG_CTRL: ctrl <= WDATA;
                `RCFS_REG_DIAG: diag <= WDATA;
                `RCFS_REG_DEAD: dead_ms <= WDATA;
                default: ;
            endcase
        end
        // Register reads, answered next cycle
        // The read data drop back to zero after one cycle so a stale
        // value is never mistaken for a fresh answer.
        RDATA <= 8'h00;
        if (RD) begin
            case (ADDR)
                `RCFS_REG_CTRL: RDATA <= ctrl;
                `RCFS_REG_STATUS: RDATA <= {SYNC_MODE, REDUNDANT_OK, fault_seen, pf_stop, 1'b0, MODE};
                `RCFS_REG_CAP_ADDR: RDATA <= cap_addr[7:0];
                `RCFS_REG_CAP_CTRL: RDATA <= {cap_ctrl, cap_addr[15:12]};
                `RCFS_REG_DIAG: RDATA <= diag;
                `RCFS_REG_DEAD: RDATA <= dead_ms;
                default: RDATA <= 8'h00;
            endcase
            // Reading the status register clears the fault flag unless a new fault lands now
            if (ADDR == `RCFS_REG_STATUS && !mismatch)
                fault_seen <= 1'b0;
        end
        // Memory protect blocks memory access and fetch, but not the memory clear pulse
        // Central reset also blocks memory, as the processor is not yet in a
        // known state and could otherwise corrupt retained user data.
        MEM_ACCESS_EN <= !MEMORY_PROTECT && !CENTRAL_RESET;
        // Power-fail: let the current instruction finish, then stop fetching
        // The stop takes effect on the same edge as the flag, so fetch can
        // never reopen in the cycle before the flag is seen.
        if (pf_block)
            pf_stop <= 1'b1;
        FETCH_EN <= (state == ST_RUN) && !pf_stop && !pf_block
            && !MEMORY_PROTECT && !PROCESS_HALT;
        if (CENTRAL_RESET) begin
            // Defined basic state while central reset is held
            state <= ST_BASIC;
            MODE <= `RCFS_MODE_PASSIVE;
            SYNC_MODE <= 1'b0;
            INTERCPU_LINK_EN <= 1'b0;
            REDUNDANT_OK <= 1'b0;
            PROCESS_HALT <= 1'b1;
            INIT_RUN <= 1'b0;
            pf_stop <= 1'b0;
        end else begin
            case (state)
                ST_BASIC: begin
                    // Supply still protecting memory: wait, per the supply's sequence
                    // Leaving early would let the processor touch memory that
                    // the supply still holds locked.
                    if (!MEMORY_PROTECT && !POWER_FAIL_WARNING) begin
                        state <= ST_INIT;
                        INIT_RUN <= 1'b1;
                    end
                end
                ST_INIT: begin
                    // Software signals the end of its initialization routine
                    // through the control register; until then it stays halted.
                    if (ctrl[`RCFS_CTRL_INIT_DONE]) begin
                        INIT_RUN <= 1'b0;
                        PROCESS_HALT <= 1'b0;
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // Synchronization run completes on software request
                    // Redundancy counts as restored only from this point on.
                    if (ctrl[`RCFS_CTRL_SYNC_REQ] && !SYNC_MODE) begin
                        SYNC_MODE <= 1'b1;
                        INTERCPU_LINK_EN <= 1'b1;
                        REDUNDANT_OK <= 1'b1;
                        ctrl[`RCFS_CTRL_SYNC_REQ] <= 1'b0;
                    end
                    // Interrupt, halt, capture and split land on the same edge;
                    // FETCH_EN drops one edge later, as it follows the registered halt, so one more fetch cycle can slip out.
                    if (mismatch) begin
                        COMPARE_MISMATCH_INTERRUPT <= 1'b1;
                        PROCESS_HALT <= 1'b1;
                        cap_addr <= OWN_ADDR;
                        cap_ctrl <= OWN_CTRL;
                        fault_seen <= 1'b1;
                        SYNC_MODE <= 1'b0;
                        INTERCPU_LINK_EN <= 1'b0;
                        REDUNDANT_OK <= 1'b0;
                        dead_cnt <= dead_cycles(dead_ms);
                        diag <= 8'h00;
                        if (ctrl[`RCFS_CTRL_LOADING]) begin
                            // Loading: no diagnosis, abort, clear memory
                            // A half-loaded image is useless on either CPU.
                            LOAD_ABORT <= 1'b1;
                            CLEAR_USER_MEM <= 1'b1;
                            ctrl[`RCFS_CTRL_LOADING] <= 1'b0;
                            state <= ST_DEAD;
                        end else if (MODE == `RCFS_MODE_BACKUP) begin
                            // A backup CPU holds no consistent data worth diagnosing.
                            CLEAR_USER_MEM <= 1'b1;
                            MODE <= `RCFS_MODE_PASSIVE;
                            state <= ST_DEAD;
                        end else begin
                            state <= ST_PRIMARY;
                        end
                    end
                end
                ST_PRIMARY: begin
                    // Primary location reads the partner's fault signals; a fatal
                    // result needs no self-test as the outcome is already fixed.
                    if (diag[`RCFS_DIAG_PRIMARY_DONE]) begin
                        if (diag[`RCFS_DIAG_PRIMARY_FOUND] || diag[`RCFS_DIAG_FATAL]) begin
                            state <= ST_RESOLVE;
                        end else begin
                            SELFTEST_START <= 1'b1;
                            state <= ST_SELFTEST;
                        end
                    end
                end
                ST_SELFTEST: begin
                    // Self-test covers processor, memory and process data paths
                    // and may take up to the longest dead time.
                    if (diag[`RCFS_DIAG_SELFTEST_DONE])
                        state <= ST_RESOLVE;
                end
                ST_RESOLVE: begin
                    // Resolution sets the mode on this one edge only; the dead time itself never moves it.
                    MODE <= next_mode;
                    CLEAR_USER_MEM <= next_clear;
                    state <= ST_DEAD;
                end
                ST_DEAD: begin
                    // User program stays suspended for the dead time
                    // Failure and stop keep the program halted afterwards; a good
                    // CPU resumes but stays uncoupled until software resyncs.
                    if (dead_cnt != 21'h000000)
                        dead_cnt <= dead_cnt - 21'h000001;
                    else begin
                        PROCESS_HALT <= (MODE == `RCFS_MODE_STOP) || (MODE == `RCFS_MODE_FAILURE);
                        state <= ST_RUN;
                    end
                end
                default: state <= ST_BASIC;
            endcase
        end
    end
end

endmodule // rcfs_supervisor
`default_nettype wire

// ===== rcfs_defs.vh
// Constants for the redundant CPU fault supervisor
`ifndef RCFS_DEFS_VH
`define RCFS_DEFS_VH
// Redundancy modes
`define RCFS_MODE_MASTER  3'h0
`define RCFS_MODE_RESERVE 3'h1
`define RCFS_MODE_BACKUP  3'h2
`define RCFS_MODE_PASSIVE 3'h3
`define RCFS_MODE_FAILURE 3'h4
`define RCFS_MODE_STOP    3'h5
// Pairing kinds
`define RCFS_PAIR_RESERVE 1'b0
`define RCFS_PAIR_BACKUP  1'b1
// Register offsets
`define RCFS_REG_CTRL     4'h0
`define RCFS_REG_STATUS   4'h1
`define RCFS_REG_CAP_ADDR 4'h2
`define RCFS_REG_CAP_CTRL 4'h3
`define RCFS_REG_DIAG     4'h4
`define RCFS_REG_DEAD     4'h5
// Control register fields
`define RCFS_CTRL_SYNC_REQ 0
`define RCFS_CTRL_LOADING  1
`define RCFS_CTRL_PAIRING  2
`define RCFS_CTRL_INIT_DONE 3
`define RCFS_CTRL_RESET    8'h00
// Diagnosis register fields
`define RCFS_DIAG_PRIMARY_DONE 0
`define RCFS_DIAG_PRIMARY_FOUND 1
`define RCFS_DIAG_SELF_FAULT 2
`define RCFS_DIAG_PARTNER_FAULT 3
`define RCFS_DIAG_FATAL 4
`define RCFS_DIAG_SELFTEST_DONE 5
// Dead time bounds in microseconds and clock
`define RCFS_CLK_MHZ 20
`define RCFS_DEAD_MIN_US 1000
`define RCFS_DEAD_MAX_US 50000
`define RCFS_DEAD_TYP_US 5000
`define RCFS_DEAD_MIN_CYC (`RCFS_DEAD_MIN_US * `RCFS_CLK_MHZ)
`define RCFS_DEAD_MAX_CYC (`RCFS_DEAD_MAX_US * `RCFS_CLK_MHZ)
`define RCFS_DEAD_TYP_CYC (`RCFS_DEAD_TYP_US * `RCFS_CLK_MHZ)
`endif

// ===== rcfs_supervisor_monitor.sv
// Assertion checker for the redundant CPU fault supervisor
`include "rcfs_defs.vh"
`default_nettype none
module rcfs_chk (
    // Clock and controls
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic CE,
    input wire logic INSTR_DONE,
    // Bus streams
    input wire logic [15:0] OWN_ADDR,
    input wire logic [15:0] PARTNER_ADDR,
    input wire logic [7:0] OWN_DATA,
    input wire logic [7:0] PARTNER_DATA,
    input wire logic [3:0] OWN_CTRL,
    input wire logic [3:0] PARTNER_CTRL,
    // Supply signals
    input wire logic POWER_FAIL_WARNING,
    input wire logic MEMORY_PROTECT,
    input wire logic CENTRAL_RESET,
    // Observed outputs
    input wire logic COMPARE_MISMATCH_INTERRUPT,
    input wire logic SYNC_MODE,
    input wire logic INTERCPU_LINK_EN,
    input wire logic REDUNDANT_OK,
    input wire logic PROCESS_HALT,
    input wire logic FETCH_EN,
    input wire logic MEM_ACCESS_EN,
    input wire logic [2:0] MODE
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (!RST_N);
    // Any difference between the two bus streams
    wire mism = OWN_ADDR != PARTNER_ADDR || OWN_DATA != PARTNER_DATA || OWN_CTRL != PARTNER_CTRL;
    // Comparison and split into asynchronous operation
    a_mismatch_irq: assert property (CE && SYNC_MODE && mism && !CENTRAL_RESET |=> COMPARE_MISMATCH_INTERRUPT)
        else $error("bus mismatch gave no interrupt");
    a_irq_pulse: assert property (COMPARE_MISMATCH_INTERRUPT |=> !COMPARE_MISMATCH_INTERRUPT)
        else $error("interrupt longer than one cycle");
    a_async_split: assert property (COMPARE_MISMATCH_INTERRUPT |-> !SYNC_MODE && !INTERCPU_LINK_EN && PROCESS_HALT)
        else $error("links or execution kept after mismatch");
    a_no_compare: assert property (!SYNC_MODE && mism |=> !COMPARE_MISMATCH_INTERRUPT)
        else $error("comparison active outside synchronous operation");
    a_tolerance_lost: assert property (!SYNC_MODE |-> !REDUNDANT_OK)
        else $error("redundancy claimed without synchronous operation");
    // Power-fail sequencing; a stopped fetch must not restart while the warning stands
    a_fetch_stop: assert property (CE && POWER_FAIL_WARNING && INSTR_DONE |=> !FETCH_EN)
        else $error("fetch continued after last instruction");
    a_fetch_held: assert property (POWER_FAIL_WARNING && !FETCH_EN |=> !FETCH_EN)
        else $error("fetch resumed under power-fail warning");
    a_mem_blocked: assert property (MEMORY_PROTECT && $past(MEMORY_PROTECT) |-> !MEM_ACCESS_EN)
        else $error("memory access while protected");
    a_central_reset: assert property (CE && CENTRAL_RESET |=> MODE == `RCFS_MODE_PASSIVE && PROCESS_HALT)
        else $error("central reset did not reach basic state");
    // Main scenarios reached
    c_irq: cover property (COMPARE_MISMATCH_INTERRUPT);
    c_fail: cover property (MODE == `RCFS_MODE_FAILURE);
    c_mem: cover property ($fell(MEM_ACCESS_EN));
    c_stop: cover property (MODE == `RCFS_MODE_STOP);
endmodule // rcfs_chk
bind rcfs_supervisor rcfs_chk rcfs_chk_i (.*);
`default_nettype wire

// ===== rcfs_far.sv
// Far side model: lock-stepped partner bus and power supply sequencing
`default_nettype none
module rcfs_far #(
    parameter int GAP = 14000
) (
    // Clock
    input wire logic clk,
    // Own bus stream and injected fault bits
    input wire logic [15:0] own_addr,
    input wire logic [7:0] own_data,
    input wire logic [3:0] own_ctrl,
    input wire logic [2:0] flt,
    // Supply switch
    input wire logic supply_on,
    // Partner bus stream
    output logic [15:0] p_addr,
    output logic [7:0] p_data,
    output logic [3:0] p_ctrl,
    // Supply signals
    output logic pfw,
    output logic mp
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt = 0;
    // Partner runs the same accesses in the same cycle unless a fault is injected
    assign p_addr = own_addr ^ {15'h0000, flt[0]};
    assign p_data = own_data ^ {7'h00, flt[1]};
    assign p_ctrl = own_ctrl ^ {3'h0, flt[2]};
    // Supply starts off
    initial begin
        pfw = 1'b1;
        mp = 1'b1;
    end
    // Protect follows warning by GAP cycles (700 us) at switch-off and switch-on alike
    always @(posedge clk) begin
        pfw <= !supply_on;
        if (mp == pfw)
            cnt <= 0;
        else if (cnt == GAP - 1) begin
            mp <= pfw;
            cnt <= 0;
        end else
            cnt <= cnt + 1;
    end
endmodule // rcfs_far
`default_nettype wire

// ===== rcfs_tb.sv
// Self-checking testbench for the redundant CPU fault supervisor
`include "rcfs_defs.vh"
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {logic [2:0] f; logic pr; logic pm; logic [7:0] dg; logic [2:0] md; logic cl;} rcfs_row_t;
    logic clk = 0, rst_n = 0, ce = 1, wr = 0, rd = 0, pm = 0, pf = 0, idone = 0, crst = 0, on = 0;
    logic [3:0] addr = '0, oc = '0, pc;
    logic [7:0] wdata = '0, od = '0, pd, rdata;
    logic [15:0] oa = '0, pa;
    logic [2:0] flt = '0, mode, seen;
    logic pfw, mp, irq, sync, link, rok, halt, fetch, mem, clr, abort, stest, init;
    int bad_count = 0, tests_run = 0, cycles = 0, n;
    // Fault kind, backup pairing, partner master, diagnosis, expected mode, memory clear
    rcfs_row_t rows [5] = '{
        '{3'h1, 1'b0, 1'b1, 8'h07, `RCFS_MODE_FAILURE, 1'b0},
        '{3'h2, 1'b0, 1'b1, 8'h0b, `RCFS_MODE_MASTER, 1'b0},
        '{3'h4, 1'b1, 1'b1, 8'h0b, `RCFS_MODE_PASSIVE, 1'b1},
        '{3'h1, 1'b0, 1'b0, 8'h11, `RCFS_MODE_STOP, 1'b0},
        '{3'h2, 1'b0, 1'b0, 8'h0f, `RCFS_MODE_FAILURE, 1'b0}};
    rcfs_supervisor rcfs_supervisor_i (.CLOCK(clk), .RST_N(rst_n), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .OWN_ADDR(oa), .PARTNER_ADDR(pa), .OWN_DATA(od), .PARTNER_DATA(pd), .OWN_CTRL(oc),
        .PARTNER_CTRL(pc), .PARTNER_IS_MASTER(pm), .PARTNER_FATAL(pf), .INSTR_DONE(idone),
        .POWER_FAIL_WARNING(pfw), .MEMORY_PROTECT(mp), .CENTRAL_RESET(crst), .COMPARE_MISMATCH_INTERRUPT(irq),
        .SYNC_MODE(sync), .INTERCPU_LINK_EN(link), .REDUNDANT_OK(rok), .PROCESS_HALT(halt), .FETCH_EN(fetch),
        .MEM_ACCESS_EN(mem), .CLEAR_USER_MEM(clr), .LOAD_ABORT(abort), .SELFTEST_START(stest), .INIT_RUN(init),
        .MODE(mode));
    rcfs_far rcfs_far_i (.clk(clk), .own_addr(oa), .own_data(od), .own_ctrl(oc), .flt(flt), .supply_on(on),
        .p_addr(pa), .p_data(pd), .p_ctrl(pc), .pfw(pfw), .mp(mp));
    // 50 ns clock
    initial forever #25 clk = ~clk;
    // Sticky record of one-cycle pulses, cleared by reset
    always @(posedge clk) seen <= rst_n ? seen | {clr, abort, stest} : 3'h0;
    // Hang guard, well above the expected run of about 50000 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            chkv(8'h00, 8'h01);
            give_verdict();
        end
    end
    task automatic give_verdict;
        if (bad_count == 0 && tests_run > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chkv(input logic [7:0] g, input logic [7:0] e);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, g, e);
        end
    endtask
    task automatic chkb(input logic g, input logic e);
        chkv({7'h00, g}, {7'h00, e});
    endtask
    task automatic chkm(input logic [2:0] g, input logic [2:0] e);
        chkv({5'h00, g}, {5'h00, e});
    endtask
    // Register port: strobes last one cycle, read data stand in the next cycle only
    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chkv(rdata & m, e);
    endtask
    // Reset, initialise, then request synchronisation
    task automatic up(input logic [7:0] c, input logic m);
        @(posedge clk);
        rst_n <= 1'b0;
        pm <= m;
        @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 50 && init !== 1'b1; i++) @(posedge clk);
        wreg(`RCFS_REG_CTRL, c | 8'h08);
        wreg(`RCFS_REG_CTRL, c | 8'h09);
        for (int i = 0; i < 200 && sync !== 1'b1; i++) @(posedge clk);
        #1 chkb(rok, 1'b1);
    endtask
    // One cycle of disagreement between the two streams
    task automatic hit(input logic [2:0] f);
        @(posedge clk);
        flt <= f;
        @(posedge clk);
        flt <= 3'h0;
        #1 chkb(irq, 1'b1);
        chkb(link, 1'b0);
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        // Supply still off: basic state, no initialisation
        repeat (20) @(posedge clk);
        #1 chkb(init, 1'b0);
        chkm(mode, `RCFS_MODE_PASSIVE);
        @(posedge clk);
        on <= 1'b1;
        for (n = 0; n < 15000 && mp !== 1'b0; n++) @(posedge clk);
        repeat (3) @(posedge clk);
        #1 chkb(init, 1'b1);
        // Resolution outcomes
        foreach (rows[i]) begin
            up({5'h00, rows[i].pr, 2'h0}, rows[i].pm);
            hit(rows[i].f);
            wreg(`RCFS_REG_DIAG, rows[i].dg);
            repeat (8) @(posedge clk);
            #1 chkm(mode, rows[i].md);
            chkb(seen[2], rows[i].cl);
        end
        // Fault while loading: no diagnosis, load aborted, memory cleared
        up(8'h02, 1'b1);
        hit(3'h4);
        repeat (8) @(posedge clk);
        #1 chkm(seen, 3'h6);
        // Unlocated fault: capture, self-test, passive CPU stays passive, timed dead time
        @(posedge clk);
        oa <= 16'ha5c3;
        oc <= 4'h9;
        up(8'h00, 1'b0);
        wreg(`RCFS_REG_DEAD, 8'h01);
        hit(3'h2);
        rreg(`RCFS_REG_STATUS, 8'hf8, 8'h20);
        rreg(`RCFS_REG_CAP_ADDR, 8'hff, 8'hc3);
        rreg(`RCFS_REG_CAP_CTRL, 8'hff, 8'h9a);
        rreg(4'hf, 8'hff, 8'h00);
        wreg(`RCFS_REG_DIAG, 8'h01);
        repeat (4) @(posedge clk);
        #1 chkb(seen[0], 1'b1);
        wreg(`RCFS_REG_DIAG, 8'h21);
        for (n = 0; n < 25000 && halt === 1'b1; n++) @(posedge clk);
        #1 chkb(n > 19995 && n < 20010, 1'b1);
        chkm(mode, `RCFS_MODE_PASSIVE);
        chkb(mem, 1'b1);
        // Power fails: fetch stops after the current instruction, then memory locks
        @(posedge clk);
        on <= 1'b0;
        repeat (4) @(posedge clk);
        #1 chkb(fetch, 1'b1);
        @(posedge clk);
        idone <= 1'b1;
        @(posedge clk);
        idone <= 1'b0;
        @(posedge clk);
        #1 chkb(fetch, 1'b0);
        for (n = 0; n < 15000 && mp !== 1'b1; n++) @(posedge clk);
        repeat (2) @(posedge clk);
        #1 chkb(mem, 1'b0);
        // Central reset returns to the basic state
        @(posedge clk);
        crst <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chkm(mode, `RCFS_MODE_PASSIVE);
        chkb(halt, 1'b1);
        give_verdict();
    end
endmodule // tb
`default_nettype wire
